// >>> hdl/acc_pkg.sv
package acc_pkg;
    // Register byte offsets
    localparam logic [3:0] ACC_OFS_CSR  = 4'h0;
    localparam logic [3:0] ACC_OFS_STAT = 4'h4;
    localparam logic [3:0] ACC_OFS_MASK = 4'h8;
    // Control/status field positions
    localparam int ACC_BIT_ENA  = 7;
    localparam int ACC_BIT_REF  = 6;
    localparam int ACC_BIT_FLAG = 5;
    localparam int ACC_BIT_IEN  = 4;
    localparam int ACC_BIT_OUT  = 3;
    localparam int ACC_BIT_OPE  = 2;
    // Reset values
    localparam logic [7:0] ACC_CSR_RST  = 8'h00;
    localparam logic [1:0] ACC_INT_RST  = 2'h0;
    // Compare mode encodings
    localparam logic [1:0] ACC_MODE_FALL  = 2'h0;
    localparam logic [1:0] ACC_MODE_RISE  = 2'h1;
    localparam logic [1:0] ACC_MODE_FALL2 = 2'h2;
    localparam logic [1:0] ACC_MODE_BOTH  = 2'h3;
    // Status bit positions: compare event, bus error
    localparam int ACC_IRQ_EVT = 0;
    localparam int ACC_IRQ_ERR = 1;
    // AXI responses
    localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;
    typedef enum logic [2:0]
    {
        ACC_W_IDLE = 3'b001,
        ACC_W_RESP = 3'b010,
        ACC_W_HOLD = 3'b100
    } acc_wstate_t;
endpackage

// >>> hdl/acc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module acc_sync
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Data
    input  wire logic d,
    output var  logic q
);
    logic s1_reg;
    logic s2_reg;
    logic s1_next;
    logic s2_next;

    always_comb
    begin
        s1_next = d;
        s2_next = s1_reg;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign q = s2_reg;
endmodule
`default_nettype wire

// >>> hdl/acc_top.sv
// Operation
// - Bit 7 enables the comparator; cleared disables it.
// - Bit 6 picks non-inverting input: 0 external pin, 1 bandgap.
// - Bit 5 flag sets on the compare event chosen by the mode field.
// - Writing one to the flag clears it; writing zero leaves it.
// - Interrupt request while flag set and bit 4 enable is one.
// - Bit 3 reads the present comparator output when enabled.
// - Output status bit resets to 0, reads 0 while disabled.
// - Bit 2 drives comparator output onto the output pin.
// - Mode 00/10 falling, 01 rising, 11 either edge.
// - Result high when non-inverting input exceeds inverting input.
// - In light stop, enabled comparator keeps detecting and wakes CPU.
// - After deep stop wake-up all state is at reset values.
`timescale 1ns/1ps
`default_nettype none
module acc_top
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // AXI4-Lite write address
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output var  logic        AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output var  logic        WREADY,
    // AXI4-Lite write response
    output var  logic [1:0]  BRESP,
    output var  logic        BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output var  logic        ARREADY,
    output var  logic [31:0] RDATA,
    output var  logic [1:0]  RRESP,
    output var  logic        RVALID,
    input  wire logic        RREADY,
    // Analog front end
    input  wire logic        COMP_RESULT,
    output var  logic        COMP_ENABLE,
    output var  logic        REF_SELECT,
    // Pin and system
    output var  logic        COMP_OUT_PIN,
    output var  logic        COMP_OUT_PIN_OE,
    output var  logic        IRQ,
    output var  logic        WAKEUP
);

    ////////////////////////////////////////////////////////////////////////
    // Comparator result sync and edge detect

    logic       res_sync;
    logic       prev_reg;
    logic       prev_next;
    logic [2:0] live_reg;
    logic [2:0] live_next;
    logic [7:0] csr_reg;
    logic [7:0] csr_next;
    logic       rise;
    logic       fall;
    logic       event_hit;

    acc_sync u_sync
    (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .d     (COMP_RESULT),
        .q     (res_sync)
    );

    always_comb
    begin
        // Edges count only once both compared samples were taken while
        // enabled; the synchroniser still holds powered-down levels
        live_next = csr_reg[ACC_BIT_ENA] ? {live_reg[1:0], 1'b1} : 3'h0;
        prev_next = csr_reg[ACC_BIT_ENA] ? res_sync : 1'b0;
        rise = live_reg[2] && csr_reg[ACC_BIT_ENA] && res_sync && !prev_reg;
        fall = live_reg[2] && csr_reg[ACC_BIT_ENA] && !res_sync && prev_reg;
        case (csr_reg[1:0])
            ACC_MODE_RISE: event_hit = rise;
            ACC_MODE_BOTH: event_hit = rise || fall;
            default:       event_hit = fall;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prev_reg <= 1'b0;
            live_reg <= 3'h0;
        end
        else
        begin
            prev_reg <= prev_next;
            live_reg <= live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    acc_wstate_t wst_reg;
    acc_wstate_t wst_next;
    logic        aw_got_reg;
    logic        aw_got_next;
    logic        w_got_reg;
    logic        w_got_next;
    logic [3:0]  awa_reg;
    logic [3:0]  awa_next;
    logic [31:0] wd_reg;
    logic [31:0] wd_next;
    logic [3:0]  ws_reg;
    logic [3:0]  ws_next;
    logic [1:0]  bresp_reg;
    logic [1:0]  bresp_next;
    logic        rvalid_reg;
    logic        rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0]  rresp_reg;
    logic [1:0]  rresp_next;
    logic [1:0]  stat_reg;
    logic [1:0]  stat_next;
    logic [1:0]  mask_reg;
    logic [1:0]  mask_next;
    logic        do_write;
    logic        bad_addr;
    logic [1:0]  err_ev;

    assign AWREADY = (wst_reg == ACC_W_IDLE) && !aw_got_reg;
    assign WREADY  = (wst_reg == ACC_W_IDLE) && !w_got_reg;
    assign BVALID  = (wst_reg == ACC_W_RESP);
    assign BRESP   = bresp_reg;
    assign ARREADY = !rvalid_reg;
    assign RVALID  = rvalid_reg;
    assign RDATA   = rdata_reg;
    assign RRESP   = rresp_reg;

    always_comb
    begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awa_next    = awa_reg;
        wd_next     = wd_reg;
        ws_next     = ws_reg;
        wst_next    = wst_reg;
        bresp_next  = bresp_reg;
        do_write    = 1'b0;
        bad_addr    = 1'b0;
        if (AWVALID && AWREADY)
        begin
            aw_got_next = 1'b1;
            awa_next    = AWADDR;
        end
        if (WVALID && WREADY)
        begin
            w_got_next = 1'b1;
            wd_next    = WDATA;
            ws_next    = WSTRB;
        end
        case (wst_reg)
            ACC_W_IDLE:
                if (aw_got_reg && w_got_reg)
                    wst_next = ACC_W_HOLD;
            ACC_W_HOLD:
            begin
                do_write = 1'b1;
                if (awa_reg == ACC_OFS_CSR)
                    bad_addr = 1'b0;
                else if (awa_reg == ACC_OFS_STAT)
                    bad_addr = 1'b0;
                else if (awa_reg == ACC_OFS_MASK)
                    bad_addr = 1'b0;
                else
                    bad_addr = 1'b1;
                bresp_next  = bad_addr ? ACC_RESP_SLVERR : ACC_RESP_OKAY;
                aw_got_next = 1'b0;
                w_got_next  = 1'b0;
                wst_next    = ACC_W_RESP;
            end
            ACC_W_RESP:
                if (BREADY)
                    wst_next = ACC_W_IDLE;
            default:
                wst_next = ACC_W_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and read path

    always_comb
    begin
        csr_next  = csr_reg;
        mask_next = mask_reg;
        err_ev    = 2'h0;
        // Set wins over a same-cycle write-one clear
        if (do_write && ws_reg[0] && awa_reg == ACC_OFS_CSR)
        begin
            csr_next[7:6] = wd_reg[7:6];
            csr_next[4]   = wd_reg[4];
            csr_next[2:0] = wd_reg[2:0];
            if (wd_reg[ACC_BIT_FLAG])
                csr_next[ACC_BIT_FLAG] = 1'b0;
        end
        else if (do_write && ws_reg[0] && awa_reg == ACC_OFS_MASK)
            mask_next = wd_reg[1:0];
        if (do_write && bad_addr)
            err_ev[ACC_IRQ_ERR] = 1'b1;
        if (event_hit)
            csr_next[ACC_BIT_FLAG] = 1'b1;
        // Output status follows the synchronised result only when enabled
        csr_next[ACC_BIT_OUT] = csr_next[ACC_BIT_ENA] && res_sync;
        if (!csr_next[ACC_BIT_ENA])
            csr_next[ACC_BIT_OUT] = 1'b0;
        err_ev[ACC_IRQ_EVT] = event_hit;
        stat_next = stat_reg;
        if (do_write && ws_reg[0] && awa_reg == ACC_OFS_STAT)
            stat_next = stat_reg & ~wd_reg[1:0];
        stat_next = stat_next | err_ev;

        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && RREADY)
            rvalid_next = 1'b0;
        if (ARVALID && ARREADY)
        begin
            rvalid_next = 1'b1;
            rresp_next  = ACC_RESP_OKAY;
            if (ARADDR == ACC_OFS_CSR)
                rdata_next = {24'h000000, csr_reg};
            else if (ARADDR == ACC_OFS_STAT)
                rdata_next = {30'h0, stat_reg};
            else if (ARADDR == ACC_OFS_MASK)
                rdata_next = {30'h0, mask_reg};
            else
            begin
                rdata_next = 32'h00000000;
                rresp_next = ACC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            // Deep stop wake-up arrives as a reset on RST_N
            csr_reg    <= ACC_CSR_RST;
            stat_reg   <= ACC_INT_RST;
            mask_reg   <= ACC_INT_RST;
            wst_reg    <= ACC_W_IDLE;
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awa_reg    <= 4'h0;
            wd_reg     <= 32'h00000000;
            ws_reg     <= 4'h0;
            bresp_reg  <= ACC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h00000000;
            rresp_reg  <= ACC_RESP_OKAY;
        end
        else
        begin
            csr_reg    <= csr_next;
            stat_reg   <= stat_next;
            mask_reg   <= mask_next;
            wst_reg    <= wst_next;
            aw_got_reg <= aw_got_next;
            w_got_reg  <= w_got_next;
            awa_reg    <= awa_next;
            wd_reg     <= wd_next;
            ws_reg     <= ws_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Analog stage compares selected input to the inverting pin
    assign COMP_ENABLE     = csr_reg[ACC_BIT_ENA];
    assign REF_SELECT      = csr_reg[ACC_BIT_REF];
    assign COMP_OUT_PIN    = csr_reg[ACC_BIT_OUT];
    assign COMP_OUT_PIN_OE = csr_reg[ACC_BIT_OPE];
    assign IRQ    = (csr_reg[ACC_BIT_FLAG] && csr_reg[ACC_BIT_IEN])
                    || |(stat_reg & mask_reg);
    assign WAKEUP = csr_reg[ACC_BIT_FLAG] && csr_reg[ACC_BIT_IEN];

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_edge_seen;
        event_hit;
    endsequence

    sequence s_settle;
        !event_hit [*3];
    endsequence

    flag_set_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        s_edge_seen |=> csr_reg[ACC_BIT_FLAG])
        else $error("flag not set after event");

    flag_clear_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        do_write && ws_reg[0] && awa_reg == ACC_OFS_CSR
        && wd_reg[ACC_BIT_FLAG] && !event_hit |=> !csr_reg[ACC_BIT_FLAG])
        else $error("flag not cleared by write one");

    flag_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        csr_reg[ACC_BIT_FLAG] && !(do_write && wd_reg[ACC_BIT_FLAG])
        |=> csr_reg[ACC_BIT_FLAG])
        else $error("flag lost without write one");

    irq_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        csr_reg[ACC_BIT_FLAG] && csr_reg[ACC_BIT_IEN] |-> IRQ && WAKEUP)
        else $error("interrupt request mismatch");

    out_disabled_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !csr_reg[ACC_BIT_ENA] |-> !csr_reg[ACC_BIT_OUT])
        else $error("output bit set while disabled");

    out_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        csr_reg[ACC_BIT_ENA] && $stable(csr_reg[ACC_BIT_ENA])
        |=> csr_reg[ACC_BIT_OUT] == (csr_reg[ACC_BIT_ENA] && $past(res_sync)))
        else $error("output bit not tracking result");

    pin_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !csr_reg[ACC_BIT_OPE] |-> !COMP_OUT_PIN_OE)
        else $error("pin driven while disabled");

    mode_rise_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        event_hit && csr_reg[1:0] == ACC_MODE_RISE |-> res_sync && !prev_reg)
        else $error("rise mode took wrong edge");

    no_false_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
        $rose(csr_reg[ACC_BIT_ENA]) |-> s_settle)
        else $error("false edge on enable");
endmodule
`default_nettype wire

// >>> bench/acc_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model
#(
    parameter logic [7:0] BANDGAP = 8'h80
)
(
    // Clock and front-end controls
    input  wire logic       clk,
    input  wire logic       enable,
    input  wire logic       ref_select,
    // Analog levels as codes
    input  wire logic [7:0] pos_level,
    input  wire logic [7:0] neg_level,
    // Comparator result
    output var  logic       result
);
    logic       noise_reg = 1'b0;
    logic [7:0] plus_in;
    ////////////////////////////////////////////////////////////////////////
    // A powered-down comparator gives no trustworthy level
    always_ff @(posedge clk)
    begin
        noise_reg <= ~noise_reg;
    end
    always_comb
    begin
        plus_in = ref_select ? BANDGAP : pos_level;
        result  = enable ? (plus_in > neg_level) : noise_reg;
    end
endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acc_pkg::*;
    logic        clock, rst_n;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        comp_result, comp_enable, ref_select;
    logic        out_pin, out_pin_oe, irq, wakeup, flag, res;
    logic [7:0]  pos_level, neg_level, p;
    logic [33:0] exp_q[$];
    int          n_mismatch, checks_done, seed;
    ////////////////////////////////////////////////////////////////////////
    acc_top acc_top_inst
    (
        .CLOCK(clock), .RST_N(rst_n),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .COMP_RESULT(comp_result), .COMP_ENABLE(comp_enable),
        .REF_SELECT(ref_select), .COMP_OUT_PIN(out_pin),
        .COMP_OUT_PIN_OE(out_pin_oe), .IRQ(irq), .WAKEUP(wakeup)
    );
    acc_cmp_model acc_cmp_model_inst
    (
        .clk(clock), .enable(comp_enable), .ref_select(ref_select),
        .pos_level(pos_level), .neg_level(neg_level), .result(comp_result)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic axw(input logic [3:0] a, input logic [7:0] d,
                       output logic [1:0] r);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= {24'($random(seed)), d};
        wstrb   <= {3'($random(seed)), 1'b1};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, input logic [33:0] e);
        @(posedge clock);
        exp_q.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic wc(input logic [7:0] d);
        axw(ACC_OFS_CSR, d, resp);
        chk(34'(resp), 34'(ACC_RESP_OKAY));
    endtask
    task automatic rc(input logic [7:0] e);
        axr(ACC_OFS_CSR, {ACC_RESP_OKAY, 24'h0, e});
    endtask
    task automatic set_lv(input logic [7:0] v);
        pos_level <= v;
        repeat (8) @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read results are matched against the oldest note
    always @(posedge clock)
        if (rvalid && rready)
            chk({rresp, rdata}, exp_q.pop_front());
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 75841;
        rst_n = 1'b0;
        {awaddr, araddr, wstrb, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        pos_level = 8'h20;
        neg_level = 8'h40;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rc(ACC_CSR_RST);
        axr(ACC_OFS_STAT, 34'h0);
        axr(ACC_OFS_MASK, 34'h0);
        chk(34'({comp_enable, irq, out_pin_oe}), 34'h0);
        for (int m = 0; m < 4; m++)
        begin
            wc(8'ha0 | 8'(m));
            repeat (8) @(posedge clock);
            rc(8'h80 | 8'(m));
            chk(34'(comp_enable), 34'h1);
            set_lv(8'hc0);
            flag = (m == 1 || m == 3);
            rc(8'h88 | {2'b0, flag, 5'h0} | 8'(m));
            wc(8'h80 | 8'(m));
            rc(8'h88 | {2'b0, flag, 5'h0} | 8'(m));
            wc(8'ha0 | 8'(m));
            rc(8'h88 | 8'(m));
            set_lv(8'h20);
            flag = (m != 1);
            rc(8'h80 | {2'b0, flag, 5'h0} | 8'(m));
        end
        // Interrupt, pin drive, status and mask
        wc(8'hb7);
        repeat (3) @(posedge clock);
        chk(34'({out_pin_oe, out_pin, irq}), 34'h4);
        set_lv(8'hc0);
        chk(34'({out_pin, irq, wakeup}), 34'h7);
        wc(8'h87);
        repeat (3) @(posedge clock);
        chk(34'(irq), 34'h0);
        axr(ACC_OFS_STAT, 34'h1);
        axw(ACC_OFS_MASK, 8'h1, resp);
        repeat (3) @(posedge clock);
        chk(34'(irq), 34'h1);
        axw(ACC_OFS_STAT, 8'h1, resp);
        repeat (3) @(posedge clock);
        chk(34'(irq), 34'h0);
        rc(8'haf);
        // Bandgap as the non-inverting input
        wc(8'he7);
        repeat (8) @(posedge clock);
        rc(8'hcf);
        neg_level <= 8'ha0;
        repeat (8) @(posedge clock);
        rc(8'he7);
        chk(34'(ref_select), 34'h1);
        neg_level <= 8'h40;
        wc(8'ha3);
        repeat (8) @(posedge clock);
        wc(8'ha3);
        res = 1'b1;
        flag = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            p = 8'($random(seed));
            if (p == 8'h40) p = 8'h41;
            set_lv(p);
            flag = flag | ((p > 8'h40) != res);
            res = (p > 8'h40);
            rc(8'h83 | {2'b0, flag, 5'h0} | {4'h0, res, 3'h0});
        end
        // Disabled reads zero and sees no edges
        wc(8'h20);
        set_lv(8'h20);
        rc(8'h00);
        chk(34'({comp_enable, out_pin}), 34'h0);
        wc(8'h83);
        repeat (8) @(posedge clock);
        rc(8'h83);
        // Unmapped address
        axw(4'hc, 8'h1, resp);
        chk(34'(resp), 34'(ACC_RESP_SLVERR));
        axr(4'hc, {ACC_RESP_SLVERR, 32'h0});
        axr(ACC_OFS_STAT, 34'h3);
        // Wake from deep stop arrives as a reset
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rc(ACC_CSR_RST);
        axr(ACC_OFS_STAT, 34'h0);
        repeat (3) @(posedge clock);
        wrap_up();
    end
endmodule
`default_nettype wire
